// ==== prog_counter_array.sv ====
// Counter array with per-module 16-bit pulse-width modulation and shared flags.
`timescale 1ns/1ps
`default_nettype none
module prog_counter_array
    import prog_counter_array_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic [NUM_MODULES-1:0] module_output_pin,
    output logic irq
);

    // Addresses below a slot wrap to large values, so one compare covers both ends.
    function automatic logic in_slot(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        return d < 8'(NUM_MODULES);
    endfunction : in_slot

    function automatic logic [2:0] slot(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        return d[2:0];
    endfunction : slot

    logic [15:0] count;
    logic [15:0] next_count;
    logic counter_run;
    logic counter_overflow_flag;
    logic overflow_irq_enable;
    logic [NUM_MODULES-1:0] module_match_flag;
    logic [7:0] module_mode_reg [NUM_MODULES];
    logic [15:0] compare_value [NUM_MODULES];
    logic ctrl_wr;
    logic cnt_low_wr;
    logic cnt_high_wr;
    logic cfg_wr;
    logic tick;
    logic overflow_evt;
    logic [NUM_MODULES-1:0] mode_wr;
    logic [NUM_MODULES-1:0] cmp_low_wr;
    logic [NUM_MODULES-1:0] cmp_high_wr;
    logic [NUM_MODULES-1:0] pwm_active;
    logic [NUM_MODULES-1:0] match_evt;
    logic [NUM_MODULES-1:0] match_irq;
    logic [7:0] next_rdata;

    always_comb
    begin
        ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
        cnt_low_wr = sfr_wr && (sfr_addr == CNT_LOW_ADDR);
        cnt_high_wr = sfr_wr && (sfr_addr == CNT_HIGH_ADDR);
        cfg_wr = sfr_wr && (sfr_addr == CNT_CFG_ADDR);
        for (int i = 0; i < NUM_MODULES; i++)
        begin
            mode_wr[i] = sfr_wr && in_slot(sfr_addr, MODE_BASE)
                && (slot(sfr_addr, MODE_BASE) == 3'(i));
            cmp_low_wr[i] = sfr_wr && in_slot(sfr_addr, CMP_LOW_BASE)
                && (slot(sfr_addr, CMP_LOW_BASE) == 3'(i));
            cmp_high_wr[i] = sfr_wr && in_slot(sfr_addr, CMP_HIGH_BASE)
                && (slot(sfr_addr, CMP_HIGH_BASE) == 3'(i));
        end
    end

    // A software write to the counter takes priority over counting in that cycle.
    assign tick = counter_run && !cnt_low_wr && !cnt_high_wr;
    assign next_count = count + 16'h0001;
    assign overflow_evt = tick && (count == CNT_LAST);

    always_comb
    begin
        for (int i = 0; i < NUM_MODULES; i++)
        begin
            pwm_active[i] = module_mode_reg[i][MODE_CMP_EN_BIT]
                && module_mode_reg[i][MODE_MOD_SEL_BIT]
                && module_mode_reg[i][MODE_WIDE_BIT];
            match_evt[i] = tick && module_mode_reg[i][MODE_CMP_EN_BIT]
                && (next_count == compare_value[i]);
            match_irq[i] = module_match_flag[i] && module_mode_reg[i][MODE_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            count <= CNT_RESET;
        else if (cnt_low_wr)
            count[7:0] <= sfr_wdata;
        else if (cnt_high_wr)
            count[15:8] <= sfr_wdata;
        else if (tick)
            count <= next_count;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            counter_run <= CTRL_RESET[CTRL_RUN_BIT];
        else if (ctrl_wr)
            counter_run <= sfr_wdata[CTRL_RUN_BIT];
    end

    // Hardware set wins over a software clear landing in the same cycle.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            counter_overflow_flag <= CTRL_RESET[CTRL_OVF_BIT];
        else if (overflow_evt)
            counter_overflow_flag <= 1'b1;
        else if (ctrl_wr)
            counter_overflow_flag <= sfr_wdata[CTRL_OVF_BIT];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            overflow_irq_enable <= CFG_RESET[CFG_OVF_IRQ_BIT];
        else if (cfg_wr)
            overflow_irq_enable <= sfr_wdata[CFG_OVF_IRQ_BIT];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            module_match_flag <= CTRL_RESET[NUM_MODULES-1:0];
        else
            for (int i = 0; i < NUM_MODULES; i++)
                if (match_evt[i])
                    module_match_flag[i] <= 1'b1;
                else if (ctrl_wr)
                    module_match_flag[i] <= sfr_wdata[i];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < NUM_MODULES; i++)
                module_mode_reg[i] <= MODE_RESET;
        else
            for (int i = 0; i < NUM_MODULES; i++)
                if (mode_wr[i])
                    module_mode_reg[i] <= sfr_wdata;
                else if (cmp_low_wr[i])
                    module_mode_reg[i][MODE_CMP_EN_BIT] <= 1'b0;
                else if (cmp_high_wr[i])
                    module_mode_reg[i][MODE_CMP_EN_BIT] <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < NUM_MODULES; i++)
                compare_value[i] <= CMP_RESET;
        else
            for (int i = 0; i < NUM_MODULES; i++)
                if (cmp_low_wr[i])
                    compare_value[i][7:0] <= sfr_wdata;
                else if (cmp_high_wr[i])
                    compare_value[i][15:8] <= sfr_wdata;
    end

    // The pin tracks the counter value being loaded, so counts below the compare value
    // are low and the rest high, which gives (65536 - compare) / 65536 high time.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            module_output_pin <= '0;
        else
            for (int i = 0; i < NUM_MODULES; i++)
                if (!pwm_active[i])
                    module_output_pin[i] <= 1'b0;
                else if (tick && next_count == CNT_RESET)
                    module_output_pin[i] <= (compare_value[i] == CNT_RESET);
                else if (tick && next_count == compare_value[i])
                    module_output_pin[i] <= 1'b1;
    end

    assign irq = (counter_overflow_flag && overflow_irq_enable) || (|match_irq);

    always_comb
    begin
        next_rdata = 8'h00;
        if (sfr_addr == CTRL_ADDR)
            next_rdata = {counter_overflow_flag, counter_run, 1'b0, module_match_flag};
        else if (sfr_addr == CNT_LOW_ADDR)
            next_rdata = count[7:0];
        else if (sfr_addr == CNT_HIGH_ADDR)
            next_rdata = count[15:8];
        else if (sfr_addr == CNT_CFG_ADDR)
            next_rdata = {7'h00, overflow_irq_enable};
        else if (in_slot(sfr_addr, MODE_BASE))
            next_rdata = module_mode_reg[slot(sfr_addr, MODE_BASE)];
        else if (in_slot(sfr_addr, CMP_LOW_BASE))
            next_rdata = compare_value[slot(sfr_addr, CMP_LOW_BASE)][7:0];
        else if (in_slot(sfr_addr, CMP_HIGH_BASE))
            next_rdata = compare_value[slot(sfr_addr, CMP_HIGH_BASE)][15:8];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= next_rdata;
    end

    property p_inactive_low;
        @(posedge core_clk) disable iff (rst)
        !pwm_active[0] |=> !module_output_pin[0];
    endproperty
    a_inactive_low: assert property (p_inactive_low) else $error("output high while mode off");

    property p_match_high;
        @(posedge core_clk) disable iff (rst)
        pwm_active[0] && tick && next_count == compare_value[0] && next_count != CNT_RESET
            |=> module_output_pin[0];
    endproperty
    a_match_high: assert property (p_match_high) else $error("output not high after match");

    property p_overflow_low;
        @(posedge core_clk) disable iff (rst)
        pwm_active[0] && overflow_evt && compare_value[0] != CNT_RESET
            |=> !module_output_pin[0];
    endproperty
    a_overflow_low: assert property (p_overflow_low) else $error("output not low after wrap");

    property p_zero_stays_high;
        @(posedge core_clk) disable iff (rst)
        pwm_active[NUM_MODULES-1] && compare_value[NUM_MODULES-1] == CNT_RESET
            && module_output_pin[NUM_MODULES-1] && !sfr_wr
            |=> module_output_pin[NUM_MODULES-1];
    endproperty
    a_zero_stays_high: assert property (p_zero_stays_high) else $error("zero compare dropped");

    property p_low_write_clears;
        @(posedge core_clk) disable iff (rst)
        cmp_low_wr[0] |=> !module_mode_reg[0][MODE_CMP_EN_BIT] ##1 !module_output_pin[0];
    endproperty
    a_low_write_clears: assert property (p_low_write_clears) else $error("enable not cleared");

    property p_high_write_sets;
        @(posedge core_clk) disable iff (rst)
        cmp_high_wr[0] |=> module_mode_reg[0][MODE_CMP_EN_BIT];
    endproperty
    a_high_write_sets: assert property (p_high_write_sets) else $error("enable not set");

    property p_match_flag_sticky;
        @(posedge core_clk) disable iff (rst)
        match_evt[0] |=> module_match_flag[0] && (module_mode_reg[0][MODE_IRQ_EN_BIT] -> irq);
    endproperty
    a_match_flag_sticky: assert property (p_match_flag_sticky) else $error("match flag lost");

    property p_overflow_flag;
        @(posedge core_clk) disable iff (rst)
        overflow_evt |=> counter_overflow_flag && count == CNT_RESET;
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set");

    property p_flag_holds;
        @(posedge core_clk) disable iff (rst)
        counter_overflow_flag && !ctrl_wr |=> counter_overflow_flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("overflow flag cleared");

    property p_counter_stops;
        @(posedge core_clk) disable iff (rst)
        !counter_run && !cnt_low_wr && !cnt_high_wr |=> $stable(count);
    endproperty
    a_counter_stops: assert property (p_counter_stops) else $error("counter moved while stopped");

endmodule : prog_counter_array
`default_nettype wire

// ==== prog_counter_array_pkg.sv ====
// Constants for the 16-bit modulation counter array block.
package prog_counter_array_pkg;
    localparam int NUM_MODULES = 5;
    localparam logic [7:0] CTRL_ADDR = 8'hD8;
    localparam logic [7:0] MODE_BASE = 8'hDA;
    localparam logic [7:0] CMP_LOW_BASE = 8'hE0;
    localparam logic [7:0] CMP_HIGH_BASE = 8'hE8;
    localparam logic [7:0] CNT_LOW_ADDR = 8'hF0;
    localparam logic [7:0] CNT_HIGH_ADDR = 8'hF1;
    localparam logic [7:0] CNT_CFG_ADDR = 8'hF2;
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int MODE_WIDE_BIT = 7;
    localparam int MODE_CMP_EN_BIT = 6;
    localparam int MODE_MATCH_FN_BIT = 3;
    localparam int MODE_MOD_SEL_BIT = 1;
    localparam int MODE_IRQ_EN_BIT = 0;
    localparam int CFG_OVF_IRQ_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_LAST = 16'hFFFF;
endpackage : prog_counter_array_pkg

// ==== prog_counter_array_tb.sv ====
// Self-checking testbench for the counter array modulation block.
`timescale 1ns/1ps
`default_nettype none
module prog_counter_array_tb;
    import prog_counter_array_pkg::*;

    logic core_clk;
    logic rst;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    logic [NUM_MODULES-1:0] module_output_pin;
    logic irq;
    int mismatches;
    int samples_checked;
    logic [7:0] rd_val;
    int waited;

    prog_counter_array u_prog_counter_array (
        .core_clk(core_clk),
        .rst(rst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata),
        .module_output_pin(module_output_pin),
        .irq(irq)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        // Return after the edge so that callers see the registers the write has just changed.
        #1;
    endtask : wr

    // Read data is registered, so it is taken one step after the edge that accepts the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask : rd

    // Counter starts at 0xFFF0, so within 30 clocks it passes any compare above 0xFFF0 and wraps.
    task automatic measure(input int m, input logic [7:0] mode, input logic [15:0] cmp,
                           input bit high_wr, input logic [15:0] exp_high,
                           input logic [7:0] exp_ctrl);
        logic [7:0] mi;
        int n;
        mi = 8'(m);
        n = 0;
        wr(CTRL_ADDR, 8'h00);
        wr(MODE_BASE + mi, 8'h00);
        wr(CNT_LOW_ADDR, 8'hF0);
        wr(CNT_HIGH_ADDR, 8'hFF);
        check({15'h0000, module_output_pin[m]}, 16'h0000);
        wr(MODE_BASE + mi, mode);
        wr(CMP_LOW_BASE + mi, cmp[7:0]);
        if (high_wr)
        begin
            wr(CMP_HIGH_BASE + mi, cmp[15:8]);
        end
        rd(MODE_BASE + mi, rd_val);
        check({8'h00, rd_val}, {8'h00, mode & 8'hBF | (high_wr ? 8'h40 : 8'h00)});
        wr(CTRL_ADDR, 8'h40);
        for (int i = 0; i < 30; i++)
        begin
            @(posedge core_clk);
            #1;
            if (module_output_pin[m] === 1'b1)
            begin
                n++;
            end
        end
        check(16'(n), exp_high);
        rd(CTRL_ADDR, rd_val);
        check({8'h00, rd_val}, {8'h00, exp_ctrl});
        // Turn the module off again so that it raises no match flag in later tests.
        wr(MODE_BASE + mi, 8'h00);
        $display("Test done: module %0d mode %h compare %h", m, mode, cmp);
    endtask : measure

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial
    begin
        mismatches = 0;
        samples_checked = 0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, reserved bit and an unmapped address.
        rd(CTRL_ADDR, rd_val);
        check({8'h00, rd_val}, {8'h00, CTRL_RESET});
        rd(MODE_BASE, rd_val);
        check({8'h00, rd_val}, {8'h00, MODE_RESET});
        rd(CNT_CFG_ADDR, rd_val);
        check({8'h00, rd_val}, {8'h00, CFG_RESET});
        wr(CTRL_ADDR, 8'h20);
        rd(CTRL_ADDR, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        wr(8'h10, 8'h5A);
        rd(8'h10, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        check({10'h000, module_output_pin, irq}, 16'h0000);
        $display("Test done: reset and register map");
        // A stopped counter keeps its value.
        wr(CNT_LOW_ADDR, 8'hF0);
        repeat (5) @(posedge core_clk);
        rd(CNT_LOW_ADDR, rd_val);
        check({8'h00, rd_val}, 16'h00F0);
        $display("Test done: counter hold");
        measure(0, 8'hC2, 16'hFFFF, 1'b1, 16'h0001, 8'hC1);
        measure(4, 8'hCA, 16'h0000, 1'b1, 16'h000F, 8'hD0);
        measure(0, 8'hC2, 16'hFFFD, 1'b0, 16'h0000, 8'hC0);
        measure(0, 8'h42, 16'hFFFD, 1'b1, 16'h0000, 8'hC1);
        measure(0, 8'hC0, 16'hFFFD, 1'b1, 16'h0000, 8'hC1);
        measure(0, 8'hC2, 16'hFFFD, 1'b1, 16'h0003, 8'hC1);
        // Flags stay set; the interrupt follows only the enabled ones.
        check({15'h0000, irq}, 16'h0000);
        wr(CNT_CFG_ADDR, 8'h01);
        check({15'h0000, irq}, 16'h0001);
        rd(CTRL_ADDR, rd_val);
        check({8'h00, rd_val}, 16'h00C1);
        wr(CTRL_ADDR, 8'h40);
        check({15'h0000, irq}, 16'h0000);
        wr(MODE_BASE, 8'hC3);
        wr(CTRL_ADDR, 8'h41);
        check({15'h0000, irq}, 16'h0001);
        $display("Test done: flags and interrupt");
        // Duty update timed to the match interrupt, low byte first.
        wr(CTRL_ADDR, 8'h00);
        wr(CNT_LOW_ADDR, 8'hF0);
        wr(CNT_HIGH_ADDR, 8'hFF);
        wr(MODE_BASE, 8'hCB);
        wr(CTRL_ADDR, 8'h40);
        waited = 0;
        while (irq !== 1'b1 && waited < 40)
        begin
            @(posedge core_clk);
            #1;
            waited++;
        end
        check(16'(waited), 16'h000D);
        check({15'h0000, module_output_pin[0]}, 16'h0001);
        wr(CMP_LOW_BASE, 8'hFE);
        wr(CMP_HIGH_BASE, 8'hFF);
        rd(MODE_BASE, rd_val);
        check({8'h00, rd_val}, 16'h00CB);
        rd(CMP_LOW_BASE, rd_val);
        check({8'h00, rd_val}, 16'h00FE);
        $display("Test done: match-timed update");
        give_verdict();
    end
endmodule : prog_counter_array_tb
`default_nettype wire
